// ### core/tsense_pkg.sv
/*
  constants, field layouts and carrier types for the sensor capability and
  configuration registers with window hysteresis.
  assumes one 20 MHz clock and a synchronous active-high reset.
*/
// Behaviour
// R1: pointer 00h reads a fixed 16-bit feature word; writes never alter it.
// R2: feature word bits 15:8 always read zero.
// R3: policy bit 0: alarm output frozen in power-down until next sample.
// R4: policy bit 1: alarm output released in power-down until next sample.
// R5: feature bit 7 mirrors bus options bit 4; the code drives the inverse of bus options bit 4.
// R6: bit 6 reads 1; stalled bus abandoned after 25 to 35 ms low.
// R7: bus timeout stays active in power-down and nonvolatile accesses.
// R8: bits 4:3 read 10, 11-bit result with 0.125 C step.
// R9: bit 2 reads 1; negative readings carry the sign bit.
// R10: bit 1 reads 1, higher accuracy grade.
// R11: bit 0 reads 1, alarm and critical interrupt capable.
// R12: bit 5 reads 1, first address pin high-voltage tolerant.
// R13: pointer 01h is a 16-bit read/write setup word.
// R14: setup bits 15:11 read zero; host writes them as zero.
// R15: hysteresis select 00 off, 01 1.5 C, 10 3 C, 11 6 C.
// R16: above flag bit 14 sets when reading exceeds upper limit.
// R17: above flag holds until reading <= upper minus hysteresis.
// R18: below flag bit 13 clears when reading >= lower limit.
// R19: below flag sets only when reading <= lower minus hysteresis.
// R20: alarm output uses the same hysteresis as the window flags; the code registers alarm_raw_i on each sample and applies no hysteresis to it.
// R21: hysteresis select writes ignored while either lock bit is set.
// R22: power-down bit set stops conversions and events.
// R23: writes to read-only registers are acknowledged but change nothing.
// R24: flags evaluated once per conversion, signed comparison.
// R25: setup word resets to zero.
package tsense_pkg;

  localparam logic [7:0] PTR_FEATURE = 8'h00;
  localparam logic [7:0] PTR_SETUP = 8'h01;
  localparam logic [15:0] SETUP_RESET = 16'h0000;

  // feature word bit positions
  localparam int FEAT_POLICY_BIT = 7;
  localparam int FEAT_TIMEOUT_BIT = 6;
  localparam int FEAT_HV_BIT = 5;
  localparam int FEAT_RES_LSB = 3;
  localparam int FEAT_WIDE_BIT = 2;
  localparam int FEAT_ACC_BIT = 1;
  localparam int FEAT_ALARM_BIT = 0;
  localparam logic [1:0] RESOLUTION_CODE = 2'h2;
  localparam int BUSOPT_FREEZE_BIT = 4;

  // setup word bit positions
  localparam int HYST_LSB = 9;
  localparam int PWRDN_BIT = 8;
  localparam int CRIT_LOCK_BIT = 7;
  localparam int WIN_LOCK_BIT = 6;
  localparam logic [15:0] SETUP_WMASK = 16'h07FF;

  // temperature result flag positions
  localparam int ABOVE_BIT = 14;
  localparam int BELOW_BIT = 13;

  // hysteresis in 1/16 C steps of the 13-bit reading
  localparam logic [12:0] HYST_1P5 = 13'h0018;
  localparam logic [12:0] HYST_3 = 13'h0030;
  localparam logic [12:0] HYST_6 = 13'h0060;

  // bus timeout window
  localparam int CLK_HZ = 20000000;
  localparam int TIMEOUT_MIN_MS = 25;
  localparam int TIMEOUT_MAX_MS = 35;
  localparam int TIMEOUT_MIN_CYC = (CLK_HZ / 1000) * TIMEOUT_MIN_MS;
  localparam int TIMEOUT_MAX_CYC = (CLK_HZ / 1000) * TIMEOUT_MAX_MS;
  localparam int TIMEOUT_CYC = (TIMEOUT_MIN_CYC + TIMEOUT_MAX_CYC) / 2;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] ptr;
    logic [15:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic signed [12:0] temp;
    logic signed [12:0] upper;
    logic signed [12:0] lower;
  } sample_type;

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_DOWN,
    PWR_WAKE
  } pwr_state_type;

endpackage

// ### core/window_compare.sv
/*
  window flag evaluator with selectable hysteresis, one step per sample.
  assumes limits and reading share one signed 13-bit format.
*/
`timescale 1ns/1ps
module window_compare (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic clear_i,
  input wire logic step_i,
  input wire tsense_pkg::sample_type sample_i,
  input wire logic [1:0] hyst_sel_i,
  output logic above_o,
  output logic below_o
);

  typedef struct packed {
    logic above;
    logic below;
  } st_type;

  st_type q, d;

  function automatic logic signed [12:0] hyst_amount(input logic [1:0] s);
    case (s)
      2'h1: hyst_amount = tsense_pkg::HYST_1P5;
      2'h2: hyst_amount = tsense_pkg::HYST_3;
      2'h3: hyst_amount = tsense_pkg::HYST_6;
      default: hyst_amount = 13'h0000;
    endcase
  endfunction

  logic signed [13:0] up_lo, lo_lo, t14;

  always_comb begin
    t14 = {sample_i.temp[12], sample_i.temp};
    up_lo = {sample_i.upper[12], sample_i.upper} -
      {1'b0, hyst_amount(hyst_sel_i)}; // R15
    lo_lo = {sample_i.lower[12], sample_i.lower} -
      {1'b0, hyst_amount(hyst_sel_i)};
    d = q;
    if (clear_i) begin
      d = '0;
    end else if (step_i) begin // R24
      if (sample_i.temp > sample_i.upper) begin
        d.above = 1'b1; // R16
      end else if (t14 <= up_lo) begin
        d.above = 1'b0; // R17
      end
      if (sample_i.temp >= sample_i.lower) begin
        d.below = 1'b0; // R18
      end else if (t14 <= lo_lo) begin
        d.below = 1'b1; // R19
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign above_o = q.above;
  assign below_o = q.below;

endmodule

// ### core/bus_timeout.sv
/*
  stalled bus detector: flags a clock line held low too long.
  assumes the clock line level is synchronous to core_clk_i.
*/
`timescale 1ns/1ps
module bus_timeout #(
  parameter int TIMEOUT_CYCLES = tsense_pkg::TIMEOUT_CYC
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic scl_low_i,
  output logic abandon_o
);

  typedef struct packed {
    logic [19:0] cnt;
    logic abandon;
  } st_type;

  st_type q, d;

  // counter runs regardless of power-down or memory access
  always_comb begin
    d = q;
    d.abandon = 1'b0;
    if (!scl_low_i) begin
      d.cnt = '0;
    end else if (q.cnt == 20'(TIMEOUT_CYCLES - 1)) begin
      d.abandon = 1'b1; // R6 R7
      d.cnt = '0;
    end else begin
      d.cnt = q.cnt + 20'h00001;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign abandon_o = q.abandon;

endmodule

// ### core/tsense_regs.sv
/*
  feature and setup registers, window flags and alarm output policy.
  assumes a pointer-addressed access port and a conversion engine that
  pulses conv_done_i with a fresh signed reading.
*/
`timescale 1ns/1ps
module tsense_regs #(
  parameter int TIMEOUT_CYCLES = tsense_pkg::TIMEOUT_CYC
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire tsense_pkg::reg_req_type req_i,
  input wire logic [7:0] bus_options_i,
  input wire logic conv_done_i,
  input wire tsense_pkg::sample_type sample_i,
  input wire logic alarm_raw_i,
  input wire logic scl_low_i,
  output logic [15:0] rdata_o,
  output logic ack_o,
  output logic [15:0] setup_o,
  output logic conv_enable_o,
  output logic above_o,
  output logic below_o,
  output logic alarm_o,
  output logic alarm_drive_o,
  output logic bus_abandon_o
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [15:0] setup;
    logic [15:0] rdata;
    logic ack;
    tsense_pkg::pwr_state_type pwr;
    logic alarm;
    logic alarm_drive;
    logic above;
    logic below;
    logic abandon;
    logic conv_en;
  } st_type;

  st_type q, d;
  logic win_above, win_below, win_clear, step, abandon;

  function automatic logic [15:0] feature_word(input logic freeze);
    logic [15:0] w;
    w = 16'h0000; // R2
    w[tsense_pkg::FEAT_POLICY_BIT] = ~freeze; // R5
    w[tsense_pkg::FEAT_TIMEOUT_BIT] = 1'b1; // R6
    w[tsense_pkg::FEAT_HV_BIT] = 1'b1; // R12
    w[tsense_pkg::FEAT_RES_LSB +: 2] = tsense_pkg::RESOLUTION_CODE; // R8
    w[tsense_pkg::FEAT_WIDE_BIT] = 1'b1; // R9
    w[tsense_pkg::FEAT_ACC_BIT] = 1'b1; // R10
    w[tsense_pkg::FEAT_ALARM_BIT] = 1'b1; // R11
    return w;
  endfunction

  logic locked, powered_down, policy_release;
  logic [15:0] wr_val;

  // ==========================================================
  // window flags
  // conversions stop in power-down, so no step can arrive then
  assign step = conv_done_i && !q.setup[tsense_pkg::PWRDN_BIT]; // R22
  assign win_clear = (q.pwr == tsense_pkg::PWR_DOWN);

  window_compare u_win (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .clear_i(win_clear),
    .step_i(step),
    .sample_i(sample_i),
    .hyst_sel_i(q.setup[tsense_pkg::HYST_LSB +: 2]),
    .above_o(win_above),
    .below_o(win_below)
  );

  bus_timeout #(
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
  ) u_tmo (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .scl_low_i(scl_low_i),
    .abandon_o(abandon)
  );

  // ==========================================================
  // next state
  always_comb begin
    d = q;
    locked = q.setup[tsense_pkg::CRIT_LOCK_BIT] ||
      q.setup[tsense_pkg::WIN_LOCK_BIT];
    powered_down = q.setup[tsense_pkg::PWRDN_BIT];
    policy_release = !bus_options_i[tsense_pkg::BUSOPT_FREEZE_BIT];
    wr_val = req_i.wdata & tsense_pkg::SETUP_WMASK; // R14
    d.ack = req_i.wr || req_i.rd; // R23
    d.above = win_above;
    d.below = win_below;
    d.abandon = abandon;

    if (req_i.wr && req_i.ptr == tsense_pkg::PTR_SETUP) begin // R13
      if (locked) begin
        // lock keeps hysteresis select from changing and power-down from being set
        wr_val[tsense_pkg::HYST_LSB +: 2] =
          q.setup[tsense_pkg::HYST_LSB +: 2]; // R21
        wr_val[tsense_pkg::PWRDN_BIT] = q.setup[tsense_pkg::PWRDN_BIT] &
          req_i.wdata[tsense_pkg::PWRDN_BIT];
      end
      d.setup = wr_val;
    end
    // feature word has no write path at all

    if (req_i.rd) begin
      case (req_i.ptr)
        tsense_pkg::PTR_FEATURE: d.rdata =
          feature_word(!policy_release); // R1
        tsense_pkg::PTR_SETUP: d.rdata = q.setup; // R14
        default: d.rdata = 16'h0000;
      endcase
    end

    case (q.pwr)
      tsense_pkg::PWR_RUN: begin
        if (step) begin
          d.alarm = alarm_raw_i; // R20
        end
        if (powered_down) begin
          d.pwr = tsense_pkg::PWR_DOWN;
          if (policy_release) begin
            d.alarm_drive = 1'b0; // R4
          end
        end
      end
      tsense_pkg::PWR_DOWN: begin
        // frozen policy leaves alarm untouched here
        if (!powered_down) begin
          d.pwr = tsense_pkg::PWR_WAKE; // R3
        end
      end
      tsense_pkg::PWR_WAKE: begin
        if (powered_down) begin
          d.pwr = tsense_pkg::PWR_DOWN;
        end else if (step) begin
          d.alarm = alarm_raw_i; // R3 R4
          d.alarm_drive = 1'b1;
          d.pwr = tsense_pkg::PWR_RUN;
        end
      end
      default: d.pwr = tsense_pkg::PWR_RUN;
    endcase
    // registered copy so the enable pin comes straight from a flop
    d.conv_en = !d.setup[tsense_pkg::PWRDN_BIT]; // R22
  end

  // ==========================================================
  // registers
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      q.setup <= tsense_pkg::SETUP_RESET; // R25
      q.rdata <= 16'h0000;
      q.ack <= 1'b0;
      q.pwr <= tsense_pkg::PWR_RUN;
      q.alarm <= 1'b0;
      q.alarm_drive <= 1'b1;
      q.above <= 1'b0;
      q.below <= 1'b0;
      q.abandon <= 1'b0;
      q.conv_en <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign rdata_o = q.rdata;
  assign ack_o = q.ack;
  assign setup_o = q.setup;
  assign conv_enable_o = q.conv_en;
  assign above_o = q.above;
  assign below_o = q.below;
  assign alarm_o = q.alarm;
  assign alarm_drive_o = q.alarm_drive;
  assign bus_abandon_o = q.abandon;

endmodule

// ### tb/tsense_regs_chk.sv
/* assertions on the ports of tsense_regs.
   assumes one clock and the synchronous reset srst_i. */
`timescale 1ns/1ps
module tsense_regs_chk #(
  parameter int TIMEOUT_CYCLES = tsense_pkg::TIMEOUT_CYC
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire tsense_pkg::reg_req_type req_i,
  input wire logic [7:0] bus_options_i,
  input wire logic conv_done_i,
  input wire tsense_pkg::sample_type sample_i,
  input wire logic scl_low_i,
  input wire logic [15:0] rdata_o,
  input wire logic ack_o,
  input wire logic [15:0] setup_o,
  input wire logic above_o,
  input wire logic below_o,
  input wire logic alarm_o,
  input wire logic alarm_drive_o,
  input wire logic bus_abandon_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  // ======
  // helper: length of the present low stretch
  int low_q;
  always_ff @(posedge core_clk_i) begin
    low_q <= (srst_i || !scl_low_i) ? 0 : low_q + 1;
  end
  sequence pd_enter;
    $rose(setup_o[8]) && !bus_options_i[4];
  endsequence
  a_feat_read: assert property (req_i.rd && req_i.ptr == 8'h00 |=> ack_o &&
    rdata_o == {8'h00, !$past(bus_options_i[4]), 7'h77})
    else $error("feature word wrong");
  a_any_ack: assert property ((req_i.rd || req_i.wr) |=> ack_o)
    else $error("access not acked");
  a_setup_read: assert property (req_i.rd && req_i.ptr == 8'h01 |=>
    rdata_o == $past(setup_o)) else $error("setup read wrong");
  a_resv_zero: assert property (setup_o[15:11] == 5'h00)
    else $error("reserved setup bits set");
  a_hyst_lock: assert property (req_i.wr && req_i.ptr == 8'h01 &&
    (setup_o[7] || setup_o[6]) |=> $stable(setup_o[10:9]))
    else $error("locked hysteresis changed");
  a_above_set: assert property (conv_done_i && !setup_o[8] &&
    sample_i.temp > sample_i.upper |-> ##2 above_o)
    else $error("above flag not set");
  a_below_clr: assert property (conv_done_i && !setup_o[8] &&
    sample_i.temp >= sample_i.lower |-> ##2 !below_o)
    else $error("below flag not cleared");
  a_pd_release: assert property (pd_enter |-> ##[1:3] !alarm_drive_o)
    else $error("alarm not released");
  a_freeze_hold: assert property (setup_o[8] && $past(setup_o[8], 2) &&
    bus_options_i[4] |-> $stable(alarm_o) && $stable(alarm_drive_o))
    else $error("frozen alarm moved");
  a_abandon_time: assert property (bus_abandon_o |-> low_q >=
    TIMEOUT_CYCLES - 1 && low_q <= TIMEOUT_CYCLES + 2)
    else $error("abandon at wrong time");
endmodule
bind tsense_regs tsense_regs_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk (
  .core_clk_i(core_clk_i), .srst_i(srst_i), .req_i(req_i),
  .bus_options_i(bus_options_i), .conv_done_i(conv_done_i),
  .sample_i(sample_i), .scl_low_i(scl_low_i), .rdata_o(rdata_o),
  .ack_o(ack_o), .setup_o(setup_o), .above_o(above_o), .below_o(below_o),
  .alarm_o(alarm_o), .alarm_drive_o(alarm_drive_o),
  .bus_abandon_o(bus_abandon_o));

// ### tb/tsense_host.sv
/* host model: pointer-addressed register accesses.
   assumes ack one cycle after the taking edge. */
`timescale 1ns/1ps
module tsense_host (
  input wire logic core_clk_i,
  input wire logic ack_i,
  input wire logic [15:0] rdata_i,
  output tsense_pkg::reg_req_type req_o
);
  initial req_o = '0;
  // released strobes drop to zero; ptr and wdata show the inverse, never a stale copy
  task automatic xfer(input logic w, input logic [7:0] p,
                      input logic [15:0] d, output logic [15:0] q);
    int n;
    n = 0;
    @(posedge core_clk_i);
    req_o <= '{wr: w, rd: !w, ptr: p, wdata: d};
    @(posedge core_clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b0, ptr: ~p, wdata: ~d};
    do begin
      @(posedge core_clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 4);
    q = (ack_i === 1'b1) ? rdata_i : 16'hXXXX;
  endtask
endmodule

// ### tb/temp_sensor_cap_config_hysteresis_tb.sv
/* testbench for tsense_regs with host model and checker.
   assumes the package and design files compile first. */
`timescale 1ns/1ps
module temp_sensor_cap_config_hysteresis_tb;
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  tsense_pkg::reg_req_type req;
  logic [7:0] bopt = 8'h00;
  logic conv = 1'b0;
  tsense_pkg::sample_type smp = '{13'h0000, 13'h0100, 13'h0050};
  logic araw = 1'b0;
  logic scl = 1'b0;
  logic [15:0] rdata, setup, q;
  logic ack, cen, above, below, alarm, drive, abandon;
  int mismatches = 0;
  int checked = 0;
  int cyc = 0;
  int pulses = 0;
  logic [12:0] h;
  always #25 core_clk_i = ~core_clk_i;
  tsense_regs #(.TIMEOUT_CYCLES(20)) dut (.core_clk_i(core_clk_i),
    .srst_i(srst_i), .req_i(req), .bus_options_i(bopt), .conv_done_i(conv),
    .sample_i(smp), .alarm_raw_i(araw), .scl_low_i(scl), .rdata_o(rdata),
    .ack_o(ack), .setup_o(setup), .conv_enable_o(cen), .above_o(above),
    .below_o(below), .alarm_o(alarm), .alarm_drive_o(drive),
    .bus_abandon_o(abandon));
  tsense_host host (.core_clk_i(core_clk_i), .ack_i(ack), .rdata_i(rdata),
    .req_o(req));
  // ======
  // tasks
  task automatic end_sim;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    host.xfer(1'b1, p, d, q);
  endtask
  task automatic rdc(input logic [7:0] p, input logic [15:0] e);
    host.xfer(1'b0, p, 16'h0000, q);
    cmp(q, e);
  endtask
  // one conversion, then flags compared three cycles on
  task automatic step(input logic [12:0] t, input logic [1:0] e);
    @(posedge core_clk_i);
    smp.temp <= t;
    conv <= 1'b1;
    @(posedge core_clk_i);
    conv <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    cmp({14'h0000, above, below}, {14'h0000, e});
  endtask
  always @(posedge core_clk_i) begin
    cyc++;
    if (abandon === 1'b1) pulses++;
    if (cyc == 6000) begin
      mismatches++;
      end_sim();
    end
  end
  // ======
  // main sequence
  initial begin
    repeat (16) @(posedge core_clk_i);
    srst_i <= 1'b0;
    cmp({14'h0000, cen, drive}, 16'h0003);
    rdc(8'h01, 16'h0000);
    rdc(8'h00, 16'h00F7);
    wr(8'h00, 16'hFFFF);
    rdc(8'h00, 16'h00F7);
    rdc(8'h40, 16'h0000);
    wr(8'h01, 16'hF600);
    rdc(8'h01, 16'h0600);
    wr(8'h01, 16'h06C0);
    wr(8'h01, 16'h00C0);
    rdc(8'h01, 16'h06C0);
    wr(8'h01, 16'h0000);
    rdc(8'h01, 16'h0600);
    for (int s = 0; s < 4; s++) begin
      h = (s == 0) ? 13'h0000 : 13'h000C << s;
      wr(8'h01, {5'h00, 2'(s), 9'h000});
      step(13'h0101, 2'b10);
      step(13'h0100, {s != 0, 1'b0});
      step(13'h0100 - h, 2'b00);
      step(13'h0050, 2'b00);
      step(13'h004F, {1'b0, s == 0});
      step(13'h004F - h, 2'b01);
    end
    araw <= 1'b1;
    step(13'h0060, 2'b00);
    cmp({14'h0000, alarm, drive}, 16'h0003);
    // raise a flag so that the power-down clear is visible
    step(13'h0101, 2'b10);
    wr(8'h01, 16'h0100);
    repeat (3) @(posedge core_clk_i);
    cmp({14'h0000, cen, drive}, 16'h0000);
    cmp({14'h0000, above, below}, 16'h0000);
    step(13'h0101, 2'b00);
    scl <= 1'b1;
    repeat (25) @(posedge core_clk_i);
    scl <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    cmp(16'(pulses), 16'h0001);
    wr(8'h01, 16'h0000);
    cmp({15'h0000, drive}, 16'h0000);
    step(13'h0060, 2'b00);
    cmp({15'h0000, drive}, 16'h0001);
    bopt <= 8'h10;
    rdc(8'h00, 16'h0077);
    wr(8'h01, 16'h0100);
    araw <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    cmp({14'h0000, alarm, drive}, 16'h0003);
    wr(8'h01, 16'h0000);
    cmp({14'h0000, alarm, drive}, 16'h0003);
    step(13'h0060, 2'b00);
    cmp({14'h0000, alarm, drive}, 16'h0001);
    end_sim();
  end
endmodule
